/* rtl/fdi_drive.v */
// drive-side interface logic of a double-sided floppy drive
// Overview of operation
// - deselected drive ignores inputs except motor, outputs off except disk change
// - activity lamp lit exactly while selected
// - motor starts only with request and disk
// - motor held while write or erase gate active
// - each selected step pulse moves one track, clamped at track 0 and the last track
// - stepping works without a disk inserted
// - direction high steps outward, low inward
// - side low picks upper head, high lower
// - head change waits for both gates high
// - selected write gate enables write current
// - write pulses recorded only while gate low
// - one index pulse per revolution when selected
// - home flag low selected and on track zero
// - write-lock flag low for protected disk, inhibits write
// - read pulse emitted for every detected bit while selected and up to speed
// - swapped flag held until insert plus step
// - read data valid after motor start time
// - no automatic home seek at power up
`timescale 1ns/10ps
`include "fdi_map.vh"
module fdi_drive #(
	parameter [31:0] REV_PERIOD_CYC = `FDI_REV_PERIOD_CYC,
	parameter [31:0] REV_WIDTH_CYC = `FDI_REV_WIDTH_CYC,
	parameter [31:0] SPIN_UP_CYC = `FDI_SPIN_UP_CYC,
	parameter [31:0] SPIN_UP_INS_CYC = `FDI_SPIN_UP_INS_CYC
) (
	input wire core_clk, // 100 MHz clock
	input wire rst, // sync reset, high
	input wire unit_pick_n, // drive select, low
	input wire spindle_run_request_n, // motor request, low
	input wire step_n, // step strobe, low
	input wire direction_n, // high outward, low inward
	input wire side_choice_n, // low upper head
	input wire record_enable_n, // write gate, low
	input wire flux_pulse_in_n, // write data strobe, low
	input wire wipe_enable_n, // erase gate, low
	input wire disk_present, // disk-in sensor, high
	input wire disk_locked, // write-protect tab, high
	input wire media_bit, // bit detected on medium, pulse
	output reg activity_lamp, // lamp on, high
	output reg rev_marker_n, // index pulse, low
	output reg home_position_flag_n, // track 00, low
	output reg lockout_flag_n, // write protect, low
	output reg recovered_flux_pulse_n, // read data, low
	output reg medium_swapped_flag_n, // disk change, low
	output reg spindle_on, // motor drive, high
	output reg write_current, // write current enable, high
	output reg upper_head, // head 1 active, high
	output reg flux_write, // one-cycle write pulse to head
	output reg speed_ok, // read data valid
	output reg [6:0] track_pos, // current track
	output reg step_inward, // one-cycle head move pulse inward
	output reg step_outward // one-cycle head move pulse outward
);
	////////////////////////////////////////////////////////////////////
	wire sel = ~unit_pick_n;
	wire gates_busy = ~record_enable_n | ~wipe_enable_n;
	wire step_trail;
	wire wd_lead;
	reg [31:0] rev_cnt_r;
	reg [31:0] spin_cnt_r;
	reg fresh_ins_r;
	reg disk_prev_r;
	reg [7:0] rd_cnt_r;
	wire rd_word;
	wire rd_valid;
	wire rd_ready = (rd_cnt_r == 8'h00);
	wire fifo_in_ready;
	wire spin_nxt;

	fdi_edge u_step (
		.core_clk(core_clk),
		.rst(rst),
		.sig_n(step_n),
		.lead(),
		.trail(step_trail)
	);
	fdi_edge u_wdata (
		.core_clk(core_clk),
		.rst(rst),
		.sig_n(flux_pulse_in_n),
		.lead(wd_lead),
		.trail()
	);
	////////////////////////////////////////////////////////////////////
	// motor: request and disk, but held by busy gates
	assign spin_nxt = (~spindle_run_request_n & disk_present)
		| (spindle_on & disk_present & gates_busy);
	always @(posedge core_clk) begin
		if (rst) begin
			spindle_on <= 1'b0;
			activity_lamp <= 1'b0;
		end else begin
			spindle_on <= spin_nxt;
			activity_lamp <= sel;
		end
	end

	////////////////////////////////////////////////////////////////////
	// spin-up timing; longer after a fresh insertion
	always @(posedge core_clk) begin
		if (rst) begin
			spin_cnt_r <= 32'h0000_0000;
			speed_ok <= 1'b0;
			fresh_ins_r <= 1'b0;
			disk_prev_r <= 1'b0;
		end else begin
			disk_prev_r <= disk_present;
			if (disk_present & ~disk_prev_r) begin
				fresh_ins_r <= 1'b1;
			end else if (speed_ok) begin
				fresh_ins_r <= 1'b0;
			end
			if (!spin_nxt) begin
				spin_cnt_r <= 32'h0000_0000;
				speed_ok <= 1'b0;
			end else if (!speed_ok) begin
				spin_cnt_r <= spin_cnt_r + 32'h0000_0001;
				// read data valid only after start time
				if (spin_cnt_r + 32'h0000_0001 >=
					(fresh_ins_r ? SPIN_UP_INS_CYC : SPIN_UP_CYC)) begin
					speed_ok <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// head positioning; counter starts at 0 but no seek is done
	always @(posedge core_clk) begin
		if (rst) begin
			track_pos <= `FDI_TRACK_RST;
			step_inward <= 1'b0;
			step_outward <= 1'b0;
		end else begin
			step_inward <= 1'b0;
			step_outward <= 1'b0;
			// disk presence not checked here
			if (sel & step_trail) begin
				if (direction_n) begin
					step_outward <= 1'b1;
					if (track_pos != 7'h00) begin
						track_pos <= track_pos - 7'h01;
					end
				end else begin
					step_inward <= 1'b1;
					if (track_pos != `FDI_LAST_TRACK) begin
						track_pos <= track_pos + 7'h01;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// head side and write path
	always @(posedge core_clk) begin
		if (rst) begin
			upper_head <= 1'b0;
			write_current <= 1'b0;
			flux_write <= 1'b0;
		end else begin
			if (sel & ~gates_busy) begin
				upper_head <= ~side_choice_n;
			end
			// protected media blocks write current
			write_current <= sel & ~record_enable_n & ~disk_locked;
			flux_write <= sel & ~record_enable_n & ~disk_locked & wd_lead;
		end
	end

	////////////////////////////////////////////////////////////////////
	// status outputs; home and lock flags released high while deselected, disk change is not
	always @(posedge core_clk) begin
		if (rst) begin
			home_position_flag_n <= 1'b1;
			lockout_flag_n <= 1'b1;
			medium_swapped_flag_n <= 1'b1;
		end else begin
			home_position_flag_n <= ~(sel & (track_pos == 7'h00));
			lockout_flag_n <= ~(sel & disk_present & disk_locked);
			// removal sets; set wins over the clearing step
			if (~disk_present) begin
				medium_swapped_flag_n <= 1'b0;
			end else if (sel & step_trail) begin
				medium_swapped_flag_n <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// index generator from spindle rotation
	always @(posedge core_clk) begin
		if (rst) begin
			rev_cnt_r <= 32'h0000_0000;
			rev_marker_n <= 1'b1;
		end else begin
			if (!spindle_on) begin
				rev_cnt_r <= 32'h0000_0000;
			end else if (rev_cnt_r >= REV_PERIOD_CYC - 32'h0000_0001) begin
				rev_cnt_r <= 32'h0000_0000;
			end else begin
				rev_cnt_r <= rev_cnt_r + 32'h0000_0001;
			end
			rev_marker_n <= ~(sel & spindle_on & (rev_cnt_r < REV_WIDTH_CYC));
		end
	end

	////////////////////////////////////////////////////////////////////
	// read path: detected bits queue here so no pulse is merged
	fdi_fifo #(
		.W(`FDI_FIFO_W),
		.D(`FDI_FIFO_D),
		.AW(`FDI_FIFO_AW)
	) u_rd_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_data(1'b1),
		.in_valid(media_bit & spindle_on),
		.in_ready(fifo_in_ready),
		.out_data(rd_word),
		.out_valid(rd_valid),
		.out_ready(rd_ready)
	);

	// pulse shaper stalls the fifo until its count has run down to zero
	always @(posedge core_clk) begin
		if (rst) begin
			rd_cnt_r <= 8'h00;
			recovered_flux_pulse_n <= 1'b1;
		end else begin
			if (rd_cnt_r != 8'h00) begin
				rd_cnt_r <= rd_cnt_r - 8'h01;
			end else if (rd_valid & rd_word) begin
				rd_cnt_r <= `FDI_RD_PULSE_CYC;
			end
			// pulse only reaches pins while selected and up to speed
			recovered_flux_pulse_n <= ~(sel & speed_ok & (rd_cnt_r > 8'h04));
		end
	end
endmodule

/* rtl/fdi_edge.v */
// edge detector for an active-low strobe, reports trailing (rising) edge
`timescale 1ns/10ps
module fdi_edge (
	input wire core_clk, // clock
	input wire rst, // sync reset, high
	input wire sig_n, // active-low strobe
	output wire lead, // falling edge seen
	output wire trail // rising edge seen
);
	reg prev_r;
	// idle level is high, so reset to high avoids a false edge
	always @(posedge core_clk) begin
		if (rst) begin
			prev_r <= 1'b1;
		end else begin
			prev_r <= sig_n;
		end
	end
	assign lead = prev_r & ~sig_n;
	assign trail = ~prev_r & sig_n;
endmodule

/* rtl/fdi_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module fdi_fifo #(
	parameter W = 1,
	parameter D = 16,
	parameter AW = 4
) (
	input wire core_clk, // clock
	input wire rst, // sync reset, high
	input wire [W-1:0] in_data, // write data
	input wire in_valid, // write request
	output wire in_ready, // not full
	output reg [W-1:0] out_data, // read data, registered
	output reg out_valid, // read data present
	input wire out_ready // consumer takes word
);
	reg [W-1:0] mem [0:D-1];
	reg [AW:0] wr_ptr_r;
	reg [AW:0] rd_ptr_r;
	wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	wire empty = (wr_ptr_r == rd_ptr_r);
	wire pop = !empty && (!out_valid || out_ready);
	assign in_ready = !full;
	// storage write, no reset needed on the array
	always @(posedge core_clk) begin
		if (in_valid && !full) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end
	// pointers and output register; output stage stalls when consumer busy
	always @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data <= {W{1'b0}};
		end else begin
			if (in_valid && !full) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (pop) begin
				out_data <= mem[rd_ptr_r[AW-1:0]];
				rd_ptr_r <= rd_ptr_r + 1'b1;
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule

/* rtl/fdi_map.vh */
// constants for the floppy drive interface logic
`ifndef FDI_MAP_VH
`define FDI_MAP_VH
`define FDI_CLK_MHZ 100
// index period and width in microseconds
`define FDI_REV_PERIOD_US 200000
`define FDI_REV_WIDTH_US 1350
`define FDI_REV_PERIOD_CYC (`FDI_REV_PERIOD_US * `FDI_CLK_MHZ)
`define FDI_REV_WIDTH_CYC (`FDI_REV_WIDTH_US * `FDI_CLK_MHZ)
// motor start times in milliseconds
`define FDI_SPIN_UP_MS 500
`define FDI_SPIN_UP_INS_MS 700
`define FDI_SPIN_UP_CYC (`FDI_SPIN_UP_MS * 1000 * `FDI_CLK_MHZ)
`define FDI_SPIN_UP_INS_CYC (`FDI_SPIN_UP_INS_MS * 1000 * `FDI_CLK_MHZ)
// track range and reset values
`define FDI_LAST_TRACK 7'h4F
`define FDI_TRACK_RST 7'h00
`define FDI_FIFO_W 1
`define FDI_FIFO_D 16
`define FDI_FIFO_AW 4
// read pulse counter reload in cycles; pin low while count above 4
`define FDI_RD_PULSE_CYC 8'h08
`endif

/* test/fdi_drive_bench.sv */
// self-checking bench for the floppy drive interface logic
`timescale 1ns/10ps
module fdi_drive_bench;
logic core_clk = 0, rst = 1, unit_pick_n = 1, spindle_run_request_n = 1, media_bit = 0;
logic side_choice_n = 1, record_enable_n = 1, flux_pulse_in_n = 1, wipe_enable_n = 1;
logic disk_present = 0, disk_locked = 0;
wire step_n, direction_n, activity_lamp, rev_marker_n, home_position_flag_n, lockout_flag_n;
wire recovered_flux_pulse_n, medium_swapped_flag_n, spindle_on, write_current, upper_head;
wire flux_write, speed_ok, step_inward, step_outward;
wire [6:0] track_pos;
int error_cnt = 0, n_tests = 0, seed = 24, i, k, j, m, t = 0;
logic [7:0] q[$];
// short counts keep the run brief
fdi_drive #(.REV_PERIOD_CYC(200), .REV_WIDTH_CYC(10), .SPIN_UP_CYC(50),
	.SPIN_UP_INS_CYC(70)) DUT (.*);
fdi_host host (.core_clk(core_clk), .step_n(step_n), .direction_n(direction_n));
initial forever #5 core_clk = ~core_clk;
task w(input int n);
	repeat (n) @(negedge core_clk);
endtask
task cmp(input string s, input logic [7:0] e, input logic [7:0] g);
	n_tests++;
	if (g !== e) begin
		error_cnt++;
		$display("BAD %s exp %h got %h", s, e, g);
	end
endtask
// expected track noted only when the drive should act
task stp(input logic o);
	if (!unit_pick_n) begin
		t = o ? ((t == 0) ? 0 : t - 1) : ((t == 79) ? 79 : t + 1);
		q.push_back({o, t[6:0]});
	end
	host.pulse(o);
endtask
task report_and_stop;
	$display("tests %0d errors %0d", n_tests, error_cnt);
	if (error_cnt == 0 && n_tests > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
// each head move pulse is checked against the oldest note, mid-cycle so it is settled
always @(negedge core_clk) begin
	if (step_inward === 1'b1 || step_outward === 1'b1) begin
		if (q.size() == 0) q.push_back(8'hFF);
		cmp("step", q.pop_front(), {step_outward, track_pos});
	end
end
initial begin
	#200000;
	error_cnt++;
	report_and_stop;
end
initial begin
	w(8);
	rst = 0;
	w(1);
	cmp("lamp", 0, activity_lamp);
	cmp("track", 0, track_pos);
	stp(0);
	cmp("track", 0, track_pos);
	unit_pick_n = 0;
	w(2);
	cmp("lamp", 1, activity_lamp);
	k = 78 + ($random(seed) & 3);
	for (i = 0; i < k; i++) stp(0); // no disk, clamps at last track when k is 80 or 81
	for (i = 0; i < k; i++) stp(1); // outward until home
	cmp("home", 0, home_position_flag_n);
	$display("step test done");
	disk_present = 1;
	spindle_run_request_n = 0;
	w(60);
	cmp("spin", 1, spindle_on);
	cmp("ready", 0, speed_ok);
	w(20);
	cmp("ready", 1, speed_ok);
	// bits seen while deselected drain without reaching the pin
	unit_pick_n = 1;
	k = 0;
	for (i = 0; i < 3; i++) begin
		media_bit = 1;
		w(1);
		media_bit = 0;
		w(2);
	end
	for (i = 0; i < 60; i++) begin
		w(1);
		k += !recovered_flux_pulse_n;
	end
	cmp("rd_desel", 0, k);
	unit_pick_n = 0;
	k = 0;
	j = 0;
	// every bit while selected gives one pulse of four low cycles
	for (i = 0; i < 20; i++) begin
		media_bit = 1;
		w(1);
		k += !recovered_flux_pulse_n;
		media_bit = 0;
		repeat (1 + ($random(seed) & 1)) begin
			w(1);
			k += !recovered_flux_pulse_n;
		end
	end
	for (i = 0; i < 400; i++) begin
		w(1);
		k += !recovered_flux_pulse_n;
		j += !rev_marker_n;
	end
	cmp("reads", 80, k);
	cmp("index", 20, j);
	$display("read test done");
	side_choice_n = 0;
	w(2);
	cmp("head", 1, upper_head);
	record_enable_n = 0;
	wipe_enable_n = 0;
	w(2);
	cmp("wcur", 1, write_current);
	side_choice_n = 1;
	spindle_run_request_n = 1;
	m = 0;
	repeat (4) begin
		flux_pulse_in_n = 0;
		w(1);
		m += flux_write;
		flux_pulse_in_n = 1;
		w(2);
	end
	cmp("fwr", 4, m);
	record_enable_n = 1;
	w(3);
	cmp("head", 1, upper_head);
	cmp("spin", 1, spindle_on);
	wipe_enable_n = 1;
	w(3);
	cmp("head", 0, upper_head);
	cmp("spin", 0, spindle_on);
	disk_locked = 1;
	record_enable_n = 0;
	w(2);
	cmp("lock", 0, lockout_flag_n);
	cmp("wcur", 0, write_current);
	record_enable_n = 1;
	disk_locked = 0;
	$display("write test done");
	disk_present = 0;
	w(2);
	cmp("swap", 0, medium_swapped_flag_n);
	disk_present = 1;
	w(2);
	cmp("swap", 0, medium_swapped_flag_n);
	stp(0);
	cmp("swap", 1, medium_swapped_flag_n);
	cmp("left", 0, q.size());
	$display("swap test done");
	report_and_stop;
end
endmodule

/* test/fdi_drive_sva.sv */
// port checker for the floppy drive interface logic
`timescale 1ns/10ps
module fdi_drive_chk (
	input wire core_clk, // clock
	input wire rst, // sync reset, high
	input wire unit_pick_n, spindle_run_request_n, step_n, direction_n, // controls
	input wire record_enable_n, flux_pulse_in_n, wipe_enable_n, // write side
	input wire disk_present, disk_locked, // sensors
	input wire activity_lamp, rev_marker_n, home_position_flag_n, // status
	input wire lockout_flag_n, recovered_flux_pulse_n, spindle_on, // status
	input wire upper_head, flux_write, step_inward, step_outward, // head side
	input wire [6:0] track_pos // current track
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
// a strobe low then high, taken while selected
sequence s_take;
	!step_n ##1 (step_n && !unit_pick_n);
endsequence
////////////////////////////////////////
a_step_out: assert property (s_take ##0 direction_n |=> step_outward &&
	track_pos == (($past(track_pos) == 7'h00) ? 7'h00 : $past(track_pos) - 7'h01))
	else $error("outward step wrong");
a_step_in: assert property (s_take ##0 !direction_n |=> step_inward &&
	track_pos == (($past(track_pos) == 7'h4F) ? 7'h4F : $past(track_pos) + 7'h01))
	else $error("inward step wrong");
a_step_desel: assert property (!step_n ##1 (step_n && unit_pick_n) |=>
	!step_inward && !step_outward) else $error("step taken while deselected");
a_lamp_sel: assert property (!$past(rst) && unit_pick_n == $past(unit_pick_n) |->
	activity_lamp == !unit_pick_n) else $error("lamp not following select");
a_out_off: assert property (!$past(rst) && unit_pick_n && $past(unit_pick_n) |->
	rev_marker_n && home_position_flag_n && recovered_flux_pulse_n && lockout_flag_n)
	else $error("output active while deselected");
a_home_trk: assert property (!$past(rst) |-> home_position_flag_n ==
	($past(unit_pick_n) || $past(track_pos) != 7'h00)) else $error("home flag wrong");
a_spin_cond: assert property (!$past(rst) && spindle_on |-> $past(disk_present) &&
	!($past(spindle_run_request_n) && $past(record_enable_n) && $past(wipe_enable_n)))
	else $error("motor running without cause");
a_spin_hold: assert property (spindle_on && disk_present &&
	!(record_enable_n && wipe_enable_n) |=> spindle_on) else $error("motor stopped in write");
a_lock_flag: assert property (!$past(rst) && !$past(unit_pick_n) && $past(disk_present) &&
	$past(disk_locked) |-> !lockout_flag_n) else $error("lock flag not shown");
a_head_hold: assert property (!(record_enable_n && wipe_enable_n) |=> $stable(upper_head))
	else $error("head changed during write");
a_flux_rec: assert property ($fell(flux_pulse_in_n) && !record_enable_n && !unit_pick_n &&
	!disk_locked |-> ##[0:2] flux_write) else $error("write pulse lost");
endmodule
bind fdi_drive fdi_drive_chk u_chk (.*);

/* test/fdi_host.sv */
// controller-side model that issues step strobes
`timescale 1ns/10ps
module fdi_host (
	input wire core_clk, // clock
	output logic step_n, // step strobe, low
	output logic direction_n // high steps outward
);
initial begin
	step_n = 1;
	direction_n = 1;
end
// direction held past the trailing edge, 2 low and 2 high cycles
task pulse(input logic o);
	@(negedge core_clk);
	direction_n = o;
	step_n = 0;
	repeat (2) @(negedge core_clk);
	step_n = 1;
	repeat (2) @(negedge core_clk);
endtask
endmodule
